// ---- inc/p3c_pkg.sv ----
// Constants and carrier types for the port 3 low-half pin function and edge interrupt block.
// Assumes a byte-wide register port within the second register bank.
package p3c_pkg;

    // ==========================================================
    // Register offsets and resets
    localparam logic [7:0] P3C_FUNC_SEL_OFS = 8'he9;
    localparam logic [7:0] P3C_IRQ_SEL_OFS = 8'hea;
    localparam logic [7:0] P3C_FUNC_SEL_RST = 8'h00;
    localparam logic [7:0] P3C_IRQ_SEL_RST = 8'h00;
    localparam logic [3:0] P3C_PEND_RST = 4'h0;
    localparam logic [2:0] P3C_SYNC_RST = 3'h0;

    // ==========================================================
    // Field layout: two bits per pin, pin n at bits 2n+1:2n (pin n+4 at bits 2n+1:2n in the edge register)
    localparam int P3C_FIELD_W = 2;
    localparam int P3C_PINS = 4;

    // ==========================================================
    // Pin function codes
    localparam logic [1:0] P3C_FN_SCHMITT = 2'h0;
    localparam logic [1:0] P3C_FN_ALT = 2'h1;
    localparam logic [1:0] P3C_FN_ANALOG = 2'h2;
    localparam logic [1:0] P3C_FN_OUTPUT = 2'h3;

    // ==========================================================
    // Edge codes
    localparam logic [1:0] P3C_EDGE_OFF = 2'h0;
    localparam logic [1:0] P3C_EDGE_FALL = 2'h1;
    localparam logic [1:0] P3C_EDGE_RISE = 2'h2;
    localparam logic [1:0] P3C_EDGE_BOTH = 2'h3;

    // ==========================================================
    // Register port request
    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } p3c_req_t;

    // Per-pin decoded function of pins 0..3
    typedef struct packed {
        logic [3:0] schmitt_in;
        logic [3:0] alt_fn;
        logic [3:0] analog_sel;
        logic [3:0] output_en;
    } p3c_func_t;

endpackage

// ---- rtl/p3c_port3_cfg.sv ----
// Port 3 low-half function select and pin 4..7 edge interrupt configuration.
// Assumes pins are asynchronous to CLK; register port is a same-clock byte port.
// Contract
// (R1) Low-half function register at e9, RW, four 2-bit fields pin3..pin0, reset zero.
// (R2) Pin 2 codes: Schmitt input, SPI clock, analog input twelve, output.
// (R3) Pin 0 codes: Schmitt input, alternate function, analog input ten, output.
// (R4) Edge interrupt register at ea, RW, reset zero, fields pin7..pin4.
// (R5) Pin 7 field: 00 disables; 01, 10, 11 enable with different edges.
// (R6) Code 01 requests interrupt on falling edges only.
// (R7) Code 10 requests interrupt on rising edges only.
// (R8) Code 11 requests interrupt on both edges.
// (R9) Pins 4, 5, 6 use the same four-code encoding.
// (R10) Pull-up forced off when pin is output or alternate function.
// (R11) Pins synchronised to CLK before edges are detected by comparison.
// (R12) Enabled edge sets pending flag held until software clears it.
`timescale 1ns/1ps

module p3c_port3_cfg
    import p3c_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire p3c_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    input wire logic [3:0] PEND_CLR,
    input wire logic [7:0] PULLUP_EN,
    input wire logic [7:0] PIN_IN,
    input wire logic [3:0] HIGH_OUT_OR_ALT,
    output p3c_func_t FUNC,
    output logic [7:0] PULLUP_ACT,
    output logic [3:0] EDGE_PULSE,
    output logic [3:0] IRQ_PEND
);

    // ==========================================================
    // Registers
    logic [7:0] func_sel_q;
    logic [7:0] irq_sel_q;
    logic [7:0] rdata_q;
    logic [3:0] pend_q;
    logic [3:0] pend_d;
    logic [3:0] edge_hit;
    logic [3:0] settled;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            func_sel_q <= P3C_FUNC_SEL_RST;
            irq_sel_q <= P3C_IRQ_SEL_RST;
        end
        else if (REG_REQ.sel && REG_REQ.wr)
        begin
            if (REG_REQ.addr == P3C_FUNC_SEL_OFS)
                func_sel_q <= REG_REQ.wdata; // R1
            if (REG_REQ.addr == P3C_IRQ_SEL_OFS)
                irq_sel_q <= REG_REQ.wdata; // R4
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            rdata_q <= 8'h00;
        else if (REG_REQ.sel && !REG_REQ.wr)
        begin
            case (REG_REQ.addr)
                P3C_FUNC_SEL_OFS: rdata_q <= func_sel_q; // R1
                P3C_IRQ_SEL_OFS: rdata_q <= irq_sel_q; // R4
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign REG_RDATA = rdata_q;

    // ==========================================================
    // Per-pin function decode and edge detect
    genvar i;
    generate
        for (i = 0; i < P3C_PINS; i++)
        begin : g_pin
            logic [1:0] fn;
            logic [1:0] ec;
            logic [2:0] sync_q;
            logic lvl_q;
            logic agree;
            logic rise;
            logic fall;
            logic hit;
            assign fn = func_sel_q[P3C_FIELD_W*i +: P3C_FIELD_W];
            assign ec = irq_sel_q[P3C_FIELD_W*i +: P3C_FIELD_W];
            // Pin 2 alt is SPI clock, pin 0 alt is its own alternate function
            assign FUNC.schmitt_in[i] = (fn == P3C_FN_SCHMITT); // R2 R3
            assign FUNC.alt_fn[i] = (fn == P3C_FN_ALT); // R2 R3
            assign FUNC.analog_sel[i] = (fn == P3C_FN_ANALOG); // R2 R3
            assign FUNC.output_en[i] = (fn == P3C_FN_OUTPUT); // R2 R3
            // Analog codes count as alternate functions, so only input keeps it
            assign PULLUP_ACT[i] = PULLUP_EN[i] && (fn == P3C_FN_SCHMITT); // R10
            assign PULLUP_ACT[i+4] = PULLUP_EN[i+4] && !HIGH_OUT_OR_ALT[i]; // R10

            // Stage 0 is only read by stage 1 to contain metastability
            always_ff @(posedge CLK or posedge RESET)
            begin
                if (RESET)
                    sync_q <= P3C_SYNC_RST;
                else
                    sync_q <= {sync_q[1:0], PIN_IN[i+4]}; // R11
            end

            // A change counts once stages 1 and 2 agree; one-cycle glitches die here
            assign agree = (sync_q[1] == sync_q[2]); // R11

            // Tracked even while disabled, so enabling later raises no stale edge
            always_ff @(posedge CLK or posedge RESET)
            begin
                if (RESET)
                    lvl_q <= P3C_SYNC_RST[2];
                else if (agree)
                    lvl_q <= sync_q[2]; // R11
            end

            assign rise = agree && sync_q[2] && !lvl_q; // R11
            assign fall = agree && !sync_q[2] && lvl_q; // R11
            always_comb
            begin
                case (ec)
                    P3C_EDGE_OFF: hit = 1'b0; // R5 R9
                    P3C_EDGE_FALL: hit = fall; // R6
                    P3C_EDGE_RISE: hit = rise; // R7
                    P3C_EDGE_BOTH: hit = rise || fall; // R8
                    default: hit = 1'b0;
                endcase
            end
            assign edge_hit[i] = hit;
            assign settled[i] = lvl_q;
        end
    endgenerate

    assign EDGE_PULSE = edge_hit;

    // ==========================================================
    // Pending flags: a new edge wins over a same-cycle clear
    assign pend_d = (pend_q & ~PEND_CLR) | edge_hit; // R12

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            pend_q <= P3C_PEND_RST;
        else
            pend_q <= pend_d; // R12
    end

    assign IRQ_PEND = pend_q;

    // ==========================================================
    // Checks: register port
    a_func_write: assert property (@(posedge CLK) disable iff (RESET) // R1
        REG_REQ.sel && REG_REQ.wr && REG_REQ.addr == P3C_FUNC_SEL_OFS
        |=> func_sel_q == $past(REG_REQ.wdata))
        else $error("function register not written");

    a_irq_write: assert property (@(posedge CLK) disable iff (RESET) // R4
        REG_REQ.sel && REG_REQ.wr && REG_REQ.addr == P3C_IRQ_SEL_OFS
        |=> irq_sel_q == $past(REG_REQ.wdata))
        else $error("interrupt register not written");

    a_func_keep: assert property (@(posedge CLK) disable iff (RESET) // R1
        !(REG_REQ.sel && REG_REQ.wr && REG_REQ.addr == P3C_FUNC_SEL_OFS)
        |=> $stable(func_sel_q))
        else $error("function register changed without a write");

    a_irq_keep: assert property (@(posedge CLK) disable iff (RESET) // R4
        !(REG_REQ.sel && REG_REQ.wr && REG_REQ.addr == P3C_IRQ_SEL_OFS)
        |=> $stable(irq_sel_q))
        else $error("interrupt register changed without a write");

    a_func_readback: assert property (@(posedge CLK) disable iff (RESET) // R1
        REG_REQ.sel && !REG_REQ.wr && REG_REQ.addr == P3C_FUNC_SEL_OFS
        |=> REG_RDATA == $past(func_sel_q))
        else $error("function register readback wrong");

    a_irq_readback: assert property (@(posedge CLK) disable iff (RESET) // R4
        REG_REQ.sel && !REG_REQ.wr && REG_REQ.addr == P3C_IRQ_SEL_OFS
        |=> REG_RDATA == $past(irq_sel_q))
        else $error("interrupt register readback wrong");

    a_unmapped_read: assert property (@(posedge CLK) disable iff (RESET) // R1
        REG_REQ.sel && !REG_REQ.wr && REG_REQ.addr != P3C_FUNC_SEL_OFS
        && REG_REQ.addr != P3C_IRQ_SEL_OFS |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_hold: assert property (@(posedge CLK) disable iff (RESET) // R1
        !(REG_REQ.sel && !REG_REQ.wr)
        |=> $stable(REG_RDATA))
        else $error("read data moved without a read");

    // ==========================================================
    // Checks: pin function and pull-up
    a_pin2_clock: assert property (@(posedge CLK) disable iff (RESET) // R2
        func_sel_q[5:4] == P3C_FN_ALT
        |-> FUNC.alt_fn[2] && !FUNC.output_en[2])
        else $error("pin 2 clock function not selected");

    a_pin2_analog: assert property (@(posedge CLK) disable iff (RESET) // R2
        func_sel_q[5:4] == P3C_FN_ANALOG
        |-> FUNC.analog_sel[2] && !FUNC.schmitt_in[2])
        else $error("pin 2 analog input not selected");

    a_pin0_analog: assert property (@(posedge CLK) disable iff (RESET) // R3
        FUNC.analog_sel[0]
        == (func_sel_q[1:0] == P3C_FN_ANALOG))
        else $error("pin 0 analog select wrong");

    a_pin0_alt: assert property (@(posedge CLK) disable iff (RESET) // R3
        FUNC.alt_fn[0]
        == (func_sel_q[1:0] == P3C_FN_ALT))
        else $error("pin 0 alternate select wrong");

    a_pin3_output: assert property (@(posedge CLK) disable iff (RESET) // R1
        func_sel_q[7:6] == P3C_FN_OUTPUT
        |-> FUNC.output_en[3] && !FUNC.schmitt_in[3])
        else $error("pin 3 field not decoded from its bits");

    a_func_onehot: assert property (@(posedge CLK) disable iff (RESET) // R2
        $onehot({FUNC.schmitt_in[2], FUNC.alt_fn[2],
        FUNC.analog_sel[2], FUNC.output_en[2]}))
        else $error("pin 2 function not one-hot");

    a_pullup_off: assert property (@(posedge CLK) disable iff (RESET) // R10
        !FUNC.schmitt_in[1]
        |-> !PULLUP_ACT[1])
        else $error("pull-up not forced off");

    a_pullup_pass: assert property (@(posedge CLK) disable iff (RESET) // R10
        FUNC.schmitt_in[3] && PULLUP_EN[3]
        |-> PULLUP_ACT[3])
        else $error("pull-up lost on input pin");

    a_pullup_high: assert property (@(posedge CLK) disable iff (RESET) // R10
        HIGH_OUT_OR_ALT[3]
        |-> !PULLUP_ACT[7])
        else $error("high pin pull-up not forced off");

    // ==========================================================
    // Checks: edge detection
    a_pin7_off: assert property (@(posedge CLK) disable iff (RESET) // R5
        irq_sel_q[7:6] == P3C_EDGE_OFF
        |-> !EDGE_PULSE[3])
        else $error("disabled pin 7 raised edge");

    a_pin4_off: assert property (@(posedge CLK) disable iff (RESET) // R9
        irq_sel_q[1:0] == P3C_EDGE_OFF
        |-> !EDGE_PULSE[0])
        else $error("disabled pin 4 raised edge");

    a_fall_edge: assert property (@(posedge CLK) disable iff (RESET) // R6
        $past(irq_sel_q[1:0]) == P3C_EDGE_FALL && $fell(settled[0])
        |-> $past(EDGE_PULSE[0]))
        else $error("falling mode missed a fall");

    a_fall_only: assert property (@(posedge CLK) disable iff (RESET) // R6
        irq_sel_q[1:0] == P3C_EDGE_FALL && EDGE_PULSE[0]
        |=> !settled[0])
        else $error("falling mode fired on rise");

    a_rise_edge: assert property (@(posedge CLK) disable iff (RESET) // R7
        $past(irq_sel_q[3:2]) == P3C_EDGE_RISE && $rose(settled[1])
        |-> $past(EDGE_PULSE[1]))
        else $error("rising mode missed a rise");

    a_rise_only: assert property (@(posedge CLK) disable iff (RESET) // R7
        irq_sel_q[3:2] == P3C_EDGE_RISE && EDGE_PULSE[1]
        |=> settled[1])
        else $error("rising mode fired on fall");

    a_both_edge: assert property (@(posedge CLK) disable iff (RESET) // R8 R9
        $past(irq_sel_q[5:4]) == P3C_EDGE_BOTH && $changed(settled[2])
        |-> $past(EDGE_PULSE[2]))
        else $error("both-edge mode missed edge");

    a_pulse_single: assert property (@(posedge CLK) disable iff (RESET) // R11
        EDGE_PULSE[3]
        |=> !EDGE_PULSE[3])
        else $error("edge pulse longer than one cycle");

    a_edge_source: assert property (@(posedge CLK) disable iff (RESET) // R11
        EDGE_PULSE[0]
        |-> $past(PIN_IN[4], 2) == $past(PIN_IN[4], 3))
        else $error("edge taken from an unsettled pin");

    // ==========================================================
    // Checks: pending flags
    a_pend_set: assert property (@(posedge CLK) disable iff (RESET) // R12
        EDGE_PULSE[0]
        |=> IRQ_PEND[0])
        else $error("pending flag not set by edge");

    a_pend_hold: assert property (@(posedge CLK) disable iff (RESET) // R12
        IRQ_PEND[1] && !PEND_CLR[1]
        |=> IRQ_PEND[1])
        else $error("pending flag lost");

    a_pend_clear: assert property (@(posedge CLK) disable iff (RESET) // R12
        PEND_CLR[2] && !EDGE_PULSE[2]
        |=> !IRQ_PEND[2])
        else $error("pending flag not cleared");

    a_pend_cause: assert property (@(posedge CLK) disable iff (RESET) // R12
        !IRQ_PEND[3] && !EDGE_PULSE[3]
        |=> !IRQ_PEND[3])
        else $error("pending flag set without edge");

endmodule // p3c_port3_cfg

// ---- verification/p3c_pin_drv.sv ----
// Partner model: external drivers on the port 3 pins.
// Assumes the bench sets the wanted levels at the falling clock edge.
`timescale 1ns/1ps

module p3c_pin_drv (
    input wire logic [7:0] LEVEL,
    output wire logic [7:0] PIN_IN
);
    // ====
    // Late settle, so pins never move on a clock edge
    assign #3 PIN_IN = LEVEL;
endmodule // p3c_pin_drv

// ---- verification/testbench.sv ----
// Self-checking bench for the port 3 pin function and edge interrupt block.
// Assumes the package, the design and the pin model are compiled first.
`timescale 1ns/1ps

module testbench;
    import p3c_pkg::*;
    logic clk = 0;
    logic reset = 1;
    p3c_req_t req = '0;
    logic [7:0] rdata, pin_in, pu_act;
    logic [7:0] pu_en = '0;
    logic [7:0] pins = '0;
    logic [3:0] clr = '0;
    logic [3:0] hoa = '0;
    logic [3:0] pulse, pend;
    p3c_func_t func;
    logic [31:0] lfsr = 32'hbd9a6f6e;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    p3c_pin_drv pins_model (.LEVEL(pins), .PIN_IN(pin_in));
    p3c_port3_cfg uut (.CLK(clk), .RESET(reset), .REG_REQ(req), .REG_RDATA(rdata),
        .PEND_CLR(clr), .PULLUP_EN(pu_en), .PIN_IN(pin_in), .HIGH_OUT_OR_ALT(hoa),
        .FUNC(func), .PULLUP_ACT(pu_act), .EDGE_PULSE(pulse), .IRQ_PEND(pend));

    // ====
    // Helpers
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic p3c_func_t fexp(input logic [7:0] r);
        p3c_func_t f;
        for (int i = 0; i < 4; i++)
        begin
            f.schmitt_in[i] = r[2*i+:2] == P3C_FN_SCHMITT;
            f.alt_fn[i] = r[2*i+:2] == P3C_FN_ALT;
            f.analog_sel[i] = r[2*i+:2] == P3C_FN_ANALOG;
            f.output_en[i] = r[2*i+:2] == P3C_FN_OUTPUT;
        end
        return f;
    endfunction

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req = '{1'b1, 1'b1, a, d};
        @(negedge clk) req = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk) req = '0;
        @(negedge clk) d = rdata;
    endtask

    // Rising needs the high bit of a field, falling the low bit
    task automatic edge_chk(input logic [7:0] cfg, input logic lvl);
        logic [3:0] e;
        logic [3:0] seen;
        seen = 4'h0;
        for (int i = 0; i < 4; i++)
            e[i] = cfg[2*i+lvl];
        @(negedge clk) pins[7:4] = {4{lvl}};
        repeat (6)
        begin
            @(negedge clk) seen = seen | pulse;
        end
        chk("edge_pulse", seen, e);
        chk("edge_pulse_end", pulse, 4'h0);
        chk("irq_pend", pend, e);
        clr = 4'hf;
        @(negedge clk) clr = 4'h0;
        @(negedge clk) chk("irq_pend_clr", pend, 4'h0);
    endtask

    task automatic results();
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ====
    // Hang guard, far above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            results();
        end
    end

    // ====
    // Main sequence
    initial
    begin
        logic [7:0] d, v;
        repeat (10) @(negedge clk);
        reset = 0;
        rd(P3C_FUNC_SEL_OFS, d);
        chk("func_sel_rst", d, P3C_FUNC_SEL_RST);
        rd(P3C_IRQ_SEL_OFS, d);
        chk("irq_sel_rst", d, P3C_IRQ_SEL_RST);
        chk("func_rst", func, fexp(8'h00));
        for (int k = 0; k < 8; k++)
        begin
            lfsr = rnd(lfsr);
            v = (k < 4) ? 8'(8'h55 * k) : lfsr[7:0];
            pu_en = lfsr[15:8];
            hoa = lfsr[19:16];
            wr(P3C_FUNC_SEL_OFS, v);
            rd(P3C_FUNC_SEL_OFS, d);
            chk("func_sel", d, v);
            chk("func", func, fexp(v));
            chk("pullup", pu_act, pu_en & ~{hoa, |v[7:6], |v[5:4], |v[3:2], |v[1:0]});
        end
        wr(8'heb, 8'hff);
        rd(8'heb, d);
        chk("unmapped", d, 8'h00);
        rd(P3C_FUNC_SEL_OFS, d);
        chk("unmapped_wr", d, v);
        v = 8'he4;
        for (int k = 0; k < 4; k++)
        begin
            wr(P3C_IRQ_SEL_OFS, v);
            rd(P3C_IRQ_SEL_OFS, d);
            chk("irq_sel", d, v);
            edge_chk(v, 1'b1);
            edge_chk(v, 1'b0);
            v = {v[1:0], v[7:2]};
        end
        // Edge and clear in one cycle: the edge wins
        wr(P3C_IRQ_SEL_OFS, 8'hff);
        @(negedge clk) pins[7:4] = 4'hf;
        clr = 4'hf;
        repeat (3) @(negedge clk);
        chk("edge_time", pulse, 4'hf);
        @(negedge clk) chk("pend_set_wins", pend, 4'hf);
        @(negedge clk) chk("pend_cleared", pend, 4'h0);
        clr = 4'h0;
        // A one-cycle dip never reaches two agreeing stages
        @(negedge clk) pins[7:4] = 4'h0;
        @(negedge clk) pins[7:4] = 4'hf;
        repeat (6) @(negedge clk);
        chk("glitch_pend", pend, 4'h0);
        // Reset in mid-run
        @(negedge clk) reset = 1;
        repeat (2) @(negedge clk);
        reset = 0;
        rd(P3C_FUNC_SEL_OFS, d);
        chk("func_sel_rerst", d, P3C_FUNC_SEL_RST);
        rd(P3C_IRQ_SEL_OFS, d);
        chk("irq_sel_rerst", d, P3C_IRQ_SEL_RST);
        chk("pend_rerst", pend, P3C_PEND_RST);
        results();
    end
endmodule // testbench
